// [hw/ccdo_core.sv]
/*
 * Executor for the call, clear-watchdog, clear, complement, decrement and
 * decrement-skip instructions, with its registers on an APB slave.
 * Assumes a 200 MHz pclk, an asynchronous active-low presetn and a
 * well-behaved APB master. Software issues one opcode at a time.
 */
`timescale 1ns/1ps
// Operation
// - A call pushes the current program counter plus one onto the stack.
// - A call loads its eleven-bit operand into program counter bits 10:0.
// - A call fills PC 12:11 from latch bits 4:3, no flags, two cycles.
// - Clear-watchdog zeroes the watchdog count and its prescaler.
// - Clear-watchdog sets timeout and power-down status bits; no other flags.
// - Clear-file writes zero to the addressed register and sets zero flag.
// - Destination bit 0 selects accumulator, 1 selects the file register.
// - Complement inverts the file register into destination, updating zero flag.
// - Clear-accumulator writes zero to the accumulator and sets zero flag.
// - Decrement subtracts one into destination, updating zero flag.
// - Decrement-skip stores like decrement, no flags, nop slot on zero.
module ccdo_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ccdo_pkg::ccdo_state_t state_q;
    logic [1:0] div_q;
    logic [13:0] opcode_q;
    logic [12:0] pc_q;
    logic [4:0] pc_latch_q;
    logic [7:0] w_q;
    logic zero_q, powerdown_status_n_q, timeout_status_n_q, refused_q;
    logic [7:0] watchdog_q, presc_q;
    logic [6:0] faddr_q;
    logic [12:0] stack_q [ccdo_pkg::STACK_DEPTH];
    logic [2:0] sp_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;

    logic cyc_en, exec_fire, tail_done, idle;
    logic is_call, is_clear_watchdog, is_clear_file, is_clear_acc;
    logic is_complement, is_decrement, is_dec_skip;
    logic dest_f, byte_op, file_we, watchdog_wrap;
    logic [7:0] file_rdata, file_wdata, result;
    logic [6:0] file_waddr, file_raddr;
    logic [12:0] stack_top;
    logic apb_setup, apb_done, wr_take, sw_ok;
    logic [31:0] rd_data;
    logic mapped;

    // ------------------------------------------------------------
    // Instruction cycle divider and decode
    // ------------------------------------------------------------
    assign cyc_en = (div_q == ccdo_pkg::DIV_LAST);
    assign idle = (state_q == ccdo_pkg::CCDO_IDLE);
    assign exec_fire = (state_q == ccdo_pkg::CCDO_EXEC) && cyc_en;
    assign tail_done = (state_q == ccdo_pkg::CCDO_TAIL) && cyc_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 2'h0;
        end else begin
            div_q <= cyc_en ? 2'h0 : div_q + 2'h1;
        end
    end

    assign is_call = (opcode_q & ccdo_pkg::CALL_MASK) == ccdo_pkg::CALL_MATCH;
    assign is_clear_watchdog = (opcode_q == ccdo_pkg::CLEAR_WATCHDOG_CODE);
    assign is_clear_file = (opcode_q & ccdo_pkg::CLR_MASK) == ccdo_pkg::CLEAR_FILE_MATCH;
    assign is_clear_acc = (opcode_q & ccdo_pkg::CLR_MASK) == ccdo_pkg::CLEAR_ACC_MATCH;
    assign is_complement = (opcode_q & ccdo_pkg::BYTE_MASK) == ccdo_pkg::COMPLEMENT_MATCH;
    assign is_decrement = (opcode_q & ccdo_pkg::BYTE_MASK) == ccdo_pkg::DECREMENT_MATCH;
    assign is_dec_skip = (opcode_q & ccdo_pkg::BYTE_MASK) == ccdo_pkg::DEC_SKIP_MATCH;
    assign dest_f = opcode_q[ccdo_pkg::DEST_BIT];
    assign byte_op = is_complement || is_decrement || is_dec_skip;

    // ------------------------------------------------------------
    // Datapath and file registers
    // ------------------------------------------------------------
    always_comb begin
        result = ccdo_pkg::BYTE_ZERO;
        if (is_complement) begin
            result = ~file_rdata;
        end else if (is_decrement || is_dec_skip) begin
            result = file_rdata - 8'h01;
        end
    end

    // Core owns the port while busy; software only reaches it when idle
    assign file_raddr = idle ? faddr_q : opcode_q[6:0];
    assign file_waddr = idle ? faddr_q : opcode_q[6:0];
    assign file_we = exec_fire ? (is_clear_file || (byte_op && dest_f))
                               : (wr_take && paddr == ccdo_pkg::OFS_FDATA && idle);
    assign file_wdata = exec_fire ? result : pwdata[7:0];

    ccdo_file_ram u_file (
        .pclk(pclk),
        .we(file_we),
        .waddr(file_waddr),
        .wdata(file_wdata),
        .raddr(file_raddr),
        .rdata(file_rdata)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ccdo_pkg::CCDO_IDLE;
        end else begin
            case (state_q)
                ccdo_pkg::CCDO_IDLE: begin
                    if (wr_take && paddr == ccdo_pkg::OFS_INSTR) begin
                        state_q <= ccdo_pkg::CCDO_EXEC;
                    end
                end
                ccdo_pkg::CCDO_EXEC: begin
                    if (exec_fire) begin
                        if (is_call || (is_dec_skip && result == ccdo_pkg::BYTE_ZERO)) begin
                            state_q <= ccdo_pkg::CCDO_TAIL;
                        end else begin
                            state_q <= ccdo_pkg::CCDO_IDLE;
                        end
                    end
                end
                default: begin
                    if (tail_done) begin
                        state_q <= ccdo_pkg::CCDO_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opcode_q <= 14'h0000;
        end else if (idle && wr_take && paddr == ccdo_pkg::OFS_INSTR) begin
            opcode_q <= pwdata[13:0];
        end
    end

    // Program counter; the skipped slot advances it a second time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= 13'h0000;
        end else if (exec_fire && is_call) begin
            pc_q <= {pc_latch_q[ccdo_pkg::LATCH_UP_HI:ccdo_pkg::LATCH_UP_LO],
                     opcode_q[10:0]};
        end else if (exec_fire || (tail_done && is_dec_skip)) begin
            pc_q <= pc_q + 13'h0001;
        end else if (idle && wr_take && paddr == ccdo_pkg::OFS_PC) begin
            pc_q <= pwdata[12:0];
        end
    end

    // Stack wraps silently when overfilled, as a hardware stack does
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_q <= 3'h0;
            for (int i = 0; i < ccdo_pkg::STACK_DEPTH; i++) begin
                stack_q[i] <= 13'h0000;
            end
        end else if (exec_fire && is_call) begin
            stack_q[sp_q] <= pc_q + 13'h0001;
            sp_q <= sp_q + 3'h1;
        end
    end
    assign stack_top = stack_q[sp_q - 3'h1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_latch_q <= 5'h00;
        end else if (idle && wr_take && paddr == ccdo_pkg::OFS_PC_LATCH) begin
            pc_latch_q <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w_q <= ccdo_pkg::BYTE_ZERO;
        end else if (exec_fire && is_clear_acc) begin
            w_q <= ccdo_pkg::BYTE_ZERO;
        end else if (exec_fire && byte_op && !dest_f) begin
            w_q <= result;
        end else if (idle && wr_take && paddr == ccdo_pkg::OFS_WACC) begin
            w_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_q <= ccdo_pkg::RST_ZERO;
        end else if (exec_fire && (is_clear_file || is_clear_acc)) begin
            zero_q <= 1'b1;
        end else if (exec_fire && (is_complement || is_decrement)) begin
            zero_q <= (result == ccdo_pkg::BYTE_ZERO);
        end else if (idle && wr_take && paddr == ccdo_pkg::OFS_STATUS) begin
            zero_q <= pwdata[ccdo_pkg::ST_ZERO];
        end
    end

    // ------------------------------------------------------------
    // Watchdog counter and prescaler
    // ------------------------------------------------------------
    assign watchdog_wrap = cyc_en && (presc_q == 8'hff) && (watchdog_q == 8'hff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= ccdo_pkg::PRESC_CLEAR;
            watchdog_q <= ccdo_pkg::WATCHDOG_CLEAR;
        end else if (exec_fire && is_clear_watchdog) begin
            presc_q <= ccdo_pkg::PRESC_CLEAR;
            watchdog_q <= ccdo_pkg::WATCHDOG_CLEAR;
        end else if (cyc_en) begin
            presc_q <= presc_q + 8'h01;
            if (presc_q == 8'hff) begin
                watchdog_q <= watchdog_q + 8'h01;
            end
        end
    end

    // A clear and a wrap can coincide; the clear is checked first and wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_status_n_q <= ccdo_pkg::RST_TIMEOUT_N;
            powerdown_status_n_q <= ccdo_pkg::RST_POWERDOWN_N;
        end else if (exec_fire && is_clear_watchdog) begin
            timeout_status_n_q <= 1'b1;
            powerdown_status_n_q <= 1'b1;
        end else if (watchdog_wrap) begin
            timeout_status_n_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // APB slave: no wait states, pready and data from flops
    // ------------------------------------------------------------
    assign apb_setup = psel && !penable;
    assign apb_done = psel && penable && pready_q;
    assign wr_take = apb_done && pwrite;
    assign sw_ok = idle || paddr == ccdo_pkg::OFS_STATUS || paddr == ccdo_pkg::OFS_FADDR;

    always_comb begin
        rd_data = 32'h0000_0000;
        mapped = 1'b1;
        if (paddr == ccdo_pkg::OFS_INSTR) begin
            rd_data = {18'h0, opcode_q};
        end else if (paddr == ccdo_pkg::OFS_STATUS) begin
            rd_data = {27'h0, refused_q, !idle, timeout_status_n_q, powerdown_status_n_q, zero_q};
        end else if (paddr == ccdo_pkg::OFS_PC) begin
            rd_data = {19'h0, pc_q};
        end else if (paddr == ccdo_pkg::OFS_PC_LATCH) begin
            rd_data = {27'h0, pc_latch_q};
        end else if (paddr == ccdo_pkg::OFS_WACC) begin
            rd_data = {24'h0, w_q};
        end else if (paddr == ccdo_pkg::OFS_STACK) begin
            rd_data = {16'h0, sp_q, stack_top};
        end else if (paddr == ccdo_pkg::OFS_WATCHDOG) begin
            rd_data = {16'h0, presc_q, watchdog_q};
        end else if (paddr == ccdo_pkg::OFS_FADDR) begin
            rd_data = {25'h0, faddr_q};
        end else if (paddr == ccdo_pkg::OFS_FDATA) begin
            rd_data = {24'h0, file_rdata};
        end else begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= apb_setup;
            pslverr_q <= apb_setup && !mapped;
            if (apb_setup && !pwrite) begin
                prdata_q <= rd_data;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            faddr_q <= 7'h00;
        end else if (wr_take && paddr == ccdo_pkg::OFS_FADDR) begin
            faddr_q <= pwdata[6:0];
        end
    end

    // Writes while busy are dropped, except OFS_FADDR and the refused-bit clear; write 1 to clear, a new refusal wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refused_q <= 1'b0;
        end else if (wr_take && mapped && !sw_ok) begin
            refused_q <= 1'b1;
        end else if (wr_take && paddr == ccdo_pkg::OFS_STATUS && pwdata[ccdo_pkg::ST_REFUSED]) begin
            refused_q <= 1'b0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_call_fire;
        exec_fire && is_call;
    endsequence
    sequence s_skip_fire;
        exec_fire && is_dec_skip && result == 8'h00;
    endsequence
    sequence s_nop_slot;
        (state_q == ccdo_pkg::CCDO_TAIL)[*4] ##1 (state_q == ccdo_pkg::CCDO_IDLE);
    endsequence

    a_call_push: assert property (s_call_fire |=> stack_top == $past(pc_q) + 13'h0001)
        else $error("call did not push return address");
    a_call_target: assert property (s_call_fire |=>
        pc_q == {$past(pc_latch_q[4:3]), $past(opcode_q[10:0])})
        else $error("call target wrong");
    a_call_two_cycles: assert property (s_call_fire |=> s_nop_slot and $stable(zero_q))
        else $error("call timing or flags wrong");
    a_watchdog_clear: assert property (exec_fire && is_clear_watchdog |=>
        watchdog_q == 8'h00 && presc_q == 8'h00)
        else $error("watchdog not cleared");
    a_watchdog_status: assert property (exec_fire && is_clear_watchdog |=>
        timeout_status_n_q && powerdown_status_n_q && $stable(zero_q))
        else $error("watchdog status bits wrong");
    a_clear_file: assert property (exec_fire && is_clear_file |-> file_we && file_wdata == 8'h00
        ##1 zero_q)
        else $error("clear file wrong");
    a_dest_accum: assert property (exec_fire && byte_op && !dest_f |->
        !file_we ##1 w_q == $past(result))
        else $error("accumulator destination wrong");
    a_dest_file: assert property (exec_fire && byte_op && dest_f |->
        file_we && file_wdata == result ##1 $stable(w_q))
        else $error("file destination wrong");
    a_comp_value: assert property (exec_fire && is_complement && !dest_f |=>
        w_q == ~$past(file_rdata))
        else $error("complement value wrong");
    a_clear_acc: assert property (exec_fire && is_clear_acc |=> w_q == 8'h00 && zero_q)
        else $error("clear accumulator wrong");
    a_dec_value: assert property (exec_fire && (is_decrement || is_dec_skip) && !dest_f |=>
        w_q == $past(file_rdata) - 8'h01)
        else $error("decrement value wrong");
    a_skip_slot: assert property (s_skip_fire |=> s_nop_slot)
        else $error("skip slot missing");
    a_skip_flags: assert property (exec_fire && is_dec_skip |=> $stable(zero_q)
        and (state_q == ccdo_pkg::CCDO_IDLE) == ($past(result) != 8'h00))
        else $error("decrement skip wrong");
    a_zero_flag: assert property (exec_fire && (is_complement || is_decrement) |=>
        zero_q == ($past(result) == 8'h00))
        else $error("zero flag wrong");
endmodule : ccdo_core

// [hw/ccdo_pkg.sv]
/*
 * Constants, register map and types for the call / clear / decrement
 * instruction group executor.
 * Assumes one 200 MHz clock and software access over APB.
 */
package ccdo_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam real CLK_PERIOD_NS = 5.0;
    // Clocks per instruction cycle
    localparam int TCY_CLKS = 4;
    localparam logic [1:0] DIV_LAST = 2'(TCY_CLKS - 1);

    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int OP_W = 14;
    localparam int PC_W = 13;
    localparam int FADDR_W = 7;
    localparam int FILE_DEPTH = 128;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int K_W = 11;

    // ------------------------------------------------------------
    // Opcode fields and encodings
    // ------------------------------------------------------------
    localparam int DEST_BIT = 7;
    localparam int LATCH_UP_HI = 4;
    localparam int LATCH_UP_LO = 3;
    localparam logic [13:0] CALL_MASK = 14'h3800;
    localparam logic [13:0] CALL_MATCH = 14'h2000;
    localparam logic [13:0] CLEAR_WATCHDOG_CODE = 14'h0064;
    localparam logic [13:0] BYTE_MASK = 14'h3f00;
    localparam logic [13:0] CLR_MASK = 14'h3f80;
    localparam logic [13:0] CLEAR_FILE_MATCH = 14'h0180;
    localparam logic [13:0] CLEAR_ACC_MATCH = 14'h0100;
    localparam logic [13:0] COMPLEMENT_MATCH = 14'h0900;
    localparam logic [13:0] DECREMENT_MATCH = 14'h0300;
    localparam logic [13:0] DEC_SKIP_MATCH = 14'h0b00;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_INSTR = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_PC = 12'h008;
    localparam logic [11:0] OFS_PC_LATCH = 12'h00c;
    localparam logic [11:0] OFS_WACC = 12'h010;
    localparam logic [11:0] OFS_STACK = 12'h014;
    localparam logic [11:0] OFS_WATCHDOG = 12'h018;
    localparam logic [11:0] OFS_FADDR = 12'h01c;
    localparam logic [11:0] OFS_FDATA = 12'h020;

    // Status register bit positions
    localparam int ST_ZERO = 0;
    localparam int ST_POWERDOWN_N = 1;
    localparam int ST_TIMEOUT_N = 2;
    localparam int ST_BUSY = 3;
    localparam int ST_REFUSED = 4;

    // Reset values
    localparam logic RST_ZERO = 1'b0;
    localparam logic RST_POWERDOWN_N = 1'b1;
    localparam logic RST_TIMEOUT_N = 1'b1;
    localparam logic [7:0] WATCHDOG_CLEAR = 8'h00;
    localparam logic [7:0] PRESC_CLEAR = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [1:0] {
        CCDO_IDLE,
        CCDO_EXEC,
        CCDO_TAIL
    } ccdo_state_t;

endpackage : ccdo_pkg

// [hw/ccdo_file_ram.sv]
/*
 * File register array: 128 bytes, one write port, one async read port.
 * Assumes the owner never writes and reads the same entry in a way that
 * needs write-through; reads see the stored value.
 */
`timescale 1ns/1ps
module ccdo_file_ram (
    input wire logic pclk,
    input wire logic we,
    input wire logic [6:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [6:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem_q [ccdo_pkg::FILE_DEPTH];

    // No reset: contents are undefined at power-up, as in a real core
    always_ff @(posedge pclk) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
    end

    assign rdata = mem_q[raddr];
endmodule : ccdo_file_ram

// [test/ccdo_core_tb.sv]
/*
 * Self-checking bench for the instruction group executor, driven over APB.
 * Assumes ccdo_core answers every access with one pready cycle.
 */
`timescale 1ns/1ps
module cpu_call_clear_decrement_ops_tb;
    typedef struct packed {
        logic [13:0] op;
        logic [6:0] f;
        logic [7:0] fin;
        logic [7:0] win;
        logic zin;
        logic [7:0] wexp;
        logic [7:0] fexp;
        logic zexp;
        logic [1:0] pcd;
    } ccdo_row_t;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int err_total = 0;
    int samples_checked = 0;
    ccdo_row_t r;
    // Flags are preset opposite to what the op should leave, except decrement-skip rows, which must keep them
    ccdo_row_t rows [9] = '{
        '{14'h0185, 7'h05, 8'h5a, 8'h33, 1'b0, 8'h33, 8'h00, 1'b1, 2'd1},
        '{14'h0100, 7'h05, 8'h77, 8'h44, 1'b0, 8'h00, 8'h77, 1'b1, 2'd1},
        '{14'h097f, 7'h7f, 8'hff, 8'h12, 1'b0, 8'h00, 8'hff, 1'b1, 2'd1},
        '{14'h0990, 7'h10, 8'h0f, 8'h12, 1'b1, 8'h12, 8'hf0, 1'b0, 2'd1},
        '{14'h0320, 7'h20, 8'h01, 8'h99, 1'b0, 8'h00, 8'h01, 1'b1, 2'd1},
        '{14'h03a0, 7'h20, 8'h00, 8'h55, 1'b1, 8'h55, 8'hff, 1'b0, 2'd1},
        '{14'h0ba1, 7'h21, 8'h02, 8'h66, 1'b1, 8'h66, 8'h01, 1'b1, 2'd1},
        '{14'h0b21, 7'h21, 8'h01, 8'h66, 1'b0, 8'h00, 8'h01, 1'b0, 2'd2},
        '{14'h0ba2, 7'h22, 8'h01, 8'h66, 1'b1, 8'h66, 8'h00, 1'b1, 2'd2}
    };

    ccdo_core dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Request held until the edge where pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk("pready", 1'b0, 1'b1);
            tally_and_finish();
        end
    endtask : apb

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, ccdo_pkg::OFS_STATUS, 32'h0);
            n++;
        end while (rd[ccdo_pkg::ST_BUSY] !== 1'b0 && n < 16);
        if (rd[ccdo_pkg::ST_BUSY] !== 1'b0) begin
            chk("busy", 1'b1, 1'b0);
            tally_and_finish();
        end
    endtask : wait_idle

    // Waits before the opcode too, so a write never lands while busy
    task automatic run(input logic [13:0] op);
        wait_idle();
        apb(1'b1, ccdo_pkg::OFS_INSTR, {18'h0, op});
        wait_idle();
    endtask : run

    task automatic reset_check();
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ccdo_pkg::OFS_STATUS, 32'h0);
        chk("status rst", rd, 32'h6);
        apb(1'b0, ccdo_pkg::OFS_PC, 32'h0);
        chk("pc rst", rd, 32'h0);
    endtask : reset_check

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        reset_check();
        foreach (rows[i]) begin
            r = rows[i];
            apb(1'b1, ccdo_pkg::OFS_FADDR, {25'h0, r.f});
            apb(1'b1, ccdo_pkg::OFS_FDATA, {24'h0, r.fin});
            apb(1'b1, ccdo_pkg::OFS_WACC, {24'h0, r.win});
            apb(1'b1, ccdo_pkg::OFS_STATUS, {31'h0, r.zin});
            apb(1'b1, ccdo_pkg::OFS_PC, 32'h100);
            run(r.op);
            apb(1'b0, ccdo_pkg::OFS_WACC, 32'h0);
            chk("wacc", rd, {24'h0, r.wexp});
            apb(1'b0, ccdo_pkg::OFS_FDATA, 32'h0);
            chk("file", rd, {24'h0, r.fexp});
            apb(1'b0, ccdo_pkg::OFS_STATUS, 32'h0);
            chk("zero", rd[0], r.zexp);
            apb(1'b0, ccdo_pkg::OFS_PC, 32'h0);
            chk("pc step", rd, 32'h100 + r.pcd);
            $display("row %0d done", i);
        end
        // Calls, the second at the top of memory so the return wraps
        apb(1'b1, ccdo_pkg::OFS_PC_LATCH, 32'h18);
        apb(1'b1, ccdo_pkg::OFS_PC, 32'h0abc);
        apb(1'b1, ccdo_pkg::OFS_STATUS, 32'h1);
        run(14'h25a5);
        apb(1'b0, ccdo_pkg::OFS_PC, 32'h0);
        chk("call pc", rd, 32'h1da5);
        apb(1'b0, ccdo_pkg::OFS_STACK, 32'h0);
        chk("call push", rd, 32'h2abd);
        apb(1'b0, ccdo_pkg::OFS_STATUS, 32'h0);
        chk("call flags", rd, 32'h7);
        apb(1'b1, ccdo_pkg::OFS_PC_LATCH, 32'h08);
        apb(1'b1, ccdo_pkg::OFS_PC, 32'h1fff);
        run(14'h27ff);
        apb(1'b0, ccdo_pkg::OFS_PC, 32'h0);
        chk("call pc top", rd, 32'h0fff);
        apb(1'b0, ccdo_pkg::OFS_STACK, 32'h0);
        chk("call push wrap", rd, 32'h4000);
        $display("call test done");
        // Watchdog clear after the prescaler has run a while
        repeat (600) @(posedge pclk);
        apb(1'b1, ccdo_pkg::OFS_STATUS, 32'h0);
        run(ccdo_pkg::CLEAR_WATCHDOG_CODE);
        apb(1'b0, ccdo_pkg::OFS_WATCHDOG, 32'h0);
        chk("watchdog count", rd[7:0], 8'h00);
        chk("watchdog presc", rd[15:8] < 8'h08, 1'b1);
        apb(1'b0, ccdo_pkg::OFS_STATUS, 32'h0);
        chk("watchdog status", rd, 32'h6);
        $display("watchdog test done");
        // Write while busy is dropped and flagged
        apb(1'b1, ccdo_pkg::OFS_INSTR, 32'h2123);
        apb(1'b1, ccdo_pkg::OFS_PC, 32'h0555);
        run(14'h0000);
        apb(1'b0, ccdo_pkg::OFS_PC, 32'h0);
        chk("busy pc", rd, 32'h0924);
        apb(1'b0, ccdo_pkg::OFS_STATUS, 32'h0);
        chk("refused", rd[ccdo_pkg::ST_REFUSED], 1'b1);
        apb(1'b1, ccdo_pkg::OFS_STATUS, 32'h10);
        apb(1'b0, ccdo_pkg::OFS_STATUS, 32'h0);
        chk("refused clr", rd[ccdo_pkg::ST_REFUSED], 1'b0);
        apb(1'b0, 12'hff0, 32'h0);
        chk("slverr", se, 1'b1);
        chk("unmapped rd", rd, 32'h0);
        $display("refusal test done");
        reset_check();
        $display("reset test done");
        tally_and_finish();
    end
endmodule : cpu_call_clear_decrement_ops_tb
